//--- hw/afsl_pkg.sv
// Package: register map, field positions, reset values and timing constants
package afsl_pkg;
	localparam int        CLK_HZ          = 40000000;
	localparam logic [7:0] REG_CONFIG     = 8'h00;
	localparam logic [7:0] REG_FAN1_CHAR  = 8'h20;
	localparam logic [7:0] REG_FAN2_CHAR  = 8'h21;
	localparam logic [7:0] REG_MIN_DUTY   = 8'h22;
	localparam logic [7:0] REG_LOCAL_THR  = 8'h24;
	localparam logic [7:0] REG_REM1_THR   = 8'h25;
	localparam logic [7:0] REG_REM2_THR   = 8'h26;
	localparam logic [7:0] REG_SW_DUTY    = 8'h30;
	localparam logic [7:0] REG_LOOP_STAT  = 8'h31;
	localparam int         AUTO_BIT       = 7;
	localparam int         SEL_HI         = 6;
	localparam int         SEL_LO         = 5;
	localparam int         SPIN_HI        = 2;
	localparam int         ONT_HI         = 7;
	localparam int         ONT_LO         = 3;
	localparam int         RANGE_HI       = 2;
	localparam logic [7:0] CONFIG_RST     = 8'h80;
	localparam logic [7:0] CHAR_RST       = 8'h1D;
	localparam logic [7:0] MIN_DUTY_RST   = 8'h55;
	localparam logic [7:0] LOCAL_THR_RST  = 8'h40;
	localparam logic [7:0] REM_THR_RST    = 8'h60;
	localparam logic [7:0] SW_DUTY_RST    = 8'h00;
	localparam logic [3:0] FULL_DUTY_CODE = 4'hF;
	localparam int         HYST_DEG       = 5;
	localparam int         ONT_STEP_DEG   = 4;
	localparam int         SPIN_UNIT_MS   = 200;
	localparam int         SPIN_UNIT_CYC  = CLK_HZ / 1000 * SPIN_UNIT_MS;
	localparam int         PWM_SLOTS      = 15;
	localparam int         PWM_SLOT_CYC   = 2048;
	typedef enum logic [1:0] {
		AFSL_OFF  = 2'b00,
		AFSL_SPIN = 2'b01,
		AFSL_RUN  = 2'b11
	} afsl_state_t;
endpackage : afsl_pkg

//--- hw/afsl_fan_channel.sv
// One fan output: start/stop hysteresis, spin-up timer and PWM generator
`timescale 1ns/10ps
`default_nettype none
module afsl_fan_channel
	import afsl_pkg::*;
#(
	parameter int SPIN_UNIT = SPIN_UNIT_CYC,
	parameter int SLOT_CYC  = PWM_SLOT_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        autoMode,
	input  wire logic        wantOn,
	input  wire logic        stayOn,
	input  wire logic [3:0]  loopDuty,
	input  wire logic [3:0]  swDuty,
	input  wire logic [2:0]  spinCode,
	output logic             pwmOut,
	output afsl_pkg::afsl_state_t fanState
);
	// Spin-up length in 200 ms units per code
	function automatic logic [5:0] spin_units(input logic [2:0] c);
		case (c)
			3'h0: spin_units = 6'h01;
			3'h1: spin_units = 6'h02;
			3'h2: spin_units = 6'h03;
			3'h3: spin_units = 6'h04;
			3'h4: spin_units = 6'h05;
			3'h5: spin_units = 6'h0A;
			3'h6: spin_units = 6'h14;
			default: spin_units = 6'h28;
		endcase
	endfunction : spin_units

	logic [31:0] unitCnt;
	logic [5:0]  unitsLeft;
	logic [31:0] slotCnt;
	logic [3:0]  slotIdx;
	logic [3:0]  duty;

	// Start, spin-up and hysteretic stop
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			fanState  <= AFSL_OFF;
			unitCnt   <= 32'h0;
			unitsLeft <= 6'h00;
		end else if (!autoMode) begin
			fanState  <= AFSL_OFF;
		end else begin
			case (fanState)
				AFSL_OFF: begin
					if (wantOn) begin
						fanState  <= AFSL_SPIN;
						unitsLeft <= spin_units(spinCode);
						unitCnt   <= 32'h0;
					end
				end
				AFSL_SPIN: begin
					if (!stayOn) begin
						fanState <= AFSL_OFF;
					end else if (unitCnt == 32'(SPIN_UNIT - 1)) begin
						unitCnt <= 32'h0;
						if (unitsLeft == 6'h01) begin
							fanState <= AFSL_RUN;
						end
						unitsLeft <= unitsLeft - 6'h01;
					end else begin
						unitCnt <= unitCnt + 32'h1;
					end
				end
				AFSL_RUN: begin
					if (!stayOn) begin
						fanState <= AFSL_OFF;
					end
				end
				default: fanState <= AFSL_OFF;
			endcase
		end
	end

	// Duty selection by mode and state
	always_comb begin
		if (!autoMode) begin
			duty = swDuty;
		end else if (fanState == AFSL_SPIN) begin
			duty = FULL_DUTY_CODE;
		end else if (fanState == AFSL_RUN) begin
			duty = loopDuty;
		end else begin
			duty = 4'h0;
		end
	end

	// PWM period of fifteen slots
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			slotCnt <= 32'h0;
			slotIdx <= 4'h0;
			pwmOut  <= 1'b0;
		end else begin
			if (slotCnt == 32'(SLOT_CYC - 1)) begin
				slotCnt <= 32'h0;
				slotIdx <= (slotIdx == 4'(PWM_SLOTS - 1)) ? 4'h0
				           : slotIdx + 4'h1;
			end else begin
				slotCnt <= slotCnt + 32'h1;
			end
			pwmOut <= (slotIdx < duty);
		end
	end
endmodule : afsl_fan_channel
`default_nettype wire

//--- hw/auto_fan_speed_loop.sv
// Top: Wishbone registers, three control loops, channel selection, two fans
// Function
// - Fan switches on at minimum duty once temperature rises above on-temperature.
// - Starting fan spins up for programmed interval before following the loop.
// - Spin-up time from characteristics bits 2:0, 200 ms to 8 s, default 2 s.
// - Config bit 7 selects automatic mode, set after reset.
// - Select 00: remote 1 drives fan 1, remote 2 drives fan 2.
// - Select 01 both fans from remote 1; 10 both from remote 2.
// - Select 11: local and remotes evaluated apart per fan, largest duty drives each fan.
// - Combining picks highest duty, not highest temperature.
// - Minimum duty code from register 0x22, n fifteenths, default 5.
// - Duty rises one step per tenth of range above on-temperature.
// - At or beyond full-speed temperature the loop saturates at full duty when the minimum code is 5 or more.
// - Running fan stops only 5 degrees below on-temperature.
// - On-temperature is bits 7:3 of threshold register, 4 degree steps.
// - Range is bits 2:0: 5, 10, 20, 40 or 80 degrees.
// - Minimum duty register: fan 1 low nibble, fan 2 high nibble.
`timescale 1ns/10ps
`default_nettype none
module auto_fan_speed_loop
	import afsl_pkg::*;
#(
	parameter int SPIN_UNIT = SPIN_UNIT_CYC,
	parameter int SLOT_CYC  = PWM_SLOT_CYC
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic [7:0]  localTemp,
	input  wire logic [7:0]  remote1Temp,
	input  wire logic [7:0]  remote2Temp,
	output logic             fan1Pwm,
	output logic             fan2Pwm
);
	logic [7:0] fanControlConfig;
	logic [7:0] fan1Characteristics;
	logic [7:0] fan2Characteristics;
	logic [7:0] minDutyConfig;
	logic [7:0] localThr;
	logic [7:0] rem1Thr;
	logic [7:0] rem2Thr;
	logic [7:0] swDutyReg;

	// Degrees per tenth of range, times ten
	function automatic logic [9:0] range_x10(input logic [2:0] c);
		case (c)
			3'h0: range_x10 = 10'd5;
			3'h1: range_x10 = 10'd10;
			3'h2: range_x10 = 10'd20;
			3'h3: range_x10 = 10'd40;
			default: range_x10 = 10'd80;
		endcase
	endfunction : range_x10

	// Loop duty: min plus steps of range/10, saturating at full
	function automatic logic [3:0] loop_duty(input logic [7:0] temp,
			input logic [7:0] thr, input logic [3:0] minCode);
		logic [9:0]  onT;
		logic [13:0] over10;
		logic [13:0] steps;
		logic [14:0] sum;
		onT    = 10'(thr[ONT_HI:ONT_LO]) * 10'(ONT_STEP_DEG);
		over10 = (10'(temp) > onT) ? 14'(10'(temp) - onT) * 14'd10
		         : 14'h0;
		steps  = over10 / 14'(range_x10(thr[RANGE_HI:0]));
		sum    = 15'(steps) + 15'(minCode);
		loop_duty = (sum >= 15'(FULL_DUTY_CODE)) ? FULL_DUTY_CODE
		            : sum[3:0];
	endfunction : loop_duty

	// Above on-temperature
	function automatic logic above_on(input logic [7:0] temp,
			input logic [7:0] thr);
		above_on = 10'(temp) > 10'(thr[ONT_HI:ONT_LO]) * 10'(ONT_STEP_DEG);
	endfunction : above_on

	// Not yet 5 degrees below on-temperature
	function automatic logic hold_on(input logic [7:0] temp,
			input logic [7:0] thr);
		hold_on = 11'(temp) + 11'(HYST_DEG)
		          > 11'(thr[ONT_HI:ONT_LO]) * 11'(ONT_STEP_DEG);
	endfunction : hold_on

	function automatic logic [3:0] max4(input logic [3:0] a,
			input logic [3:0] b);
		max4 = (a > b) ? a : b;
	endfunction : max4

	// Wishbone classic slave, one wait state, single-cycle ack
	logic wbReq;
	assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wbReq;
		end
	end

	// Register writes on lane 0
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			fanControlConfig    <= CONFIG_RST;
			fan1Characteristics <= CHAR_RST;
			fan2Characteristics <= CHAR_RST;
			minDutyConfig       <= MIN_DUTY_RST;
			localThr            <= LOCAL_THR_RST;
			rem1Thr             <= REM_THR_RST;
			rem2Thr             <= REM_THR_RST;
			swDutyReg           <= SW_DUTY_RST;
		end else if (wbReq && wb_we_i && wb_sel_i[0]) begin
			case (wb_adr_i)
				REG_CONFIG:    fanControlConfig    <= wb_dat_i[7:0];
				REG_FAN1_CHAR: fan1Characteristics <= wb_dat_i[7:0];
				REG_FAN2_CHAR: fan2Characteristics <= wb_dat_i[7:0];
				REG_MIN_DUTY:  minDutyConfig       <= wb_dat_i[7:0];
				REG_LOCAL_THR: localThr            <= wb_dat_i[7:0];
				REG_REM1_THR:  rem1Thr             <= wb_dat_i[7:0];
				REG_REM2_THR:  rem2Thr             <= wb_dat_i[7:0];
				REG_SW_DUTY:   swDutyReg           <= wb_dat_i[7:0];
				default: ;
			endcase
		end
	end

	afsl_state_t fan1State;
	afsl_state_t fan2State;
	logic [3:0]  fan1Duty;
	logic [3:0]  fan2Duty;

	// Read mux, unmapped reads return zero
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_dat_o <= 32'h0;
		end else if (wbReq) begin
			case (wb_adr_i)
				REG_CONFIG:    wb_dat_o <= {24'h0, fanControlConfig};
				REG_FAN1_CHAR: wb_dat_o <= {24'h0, fan1Characteristics};
				REG_FAN2_CHAR: wb_dat_o <= {24'h0, fan2Characteristics};
				REG_MIN_DUTY:  wb_dat_o <= {24'h0, minDutyConfig};
				REG_LOCAL_THR: wb_dat_o <= {24'h0, localThr};
				REG_REM1_THR:  wb_dat_o <= {24'h0, rem1Thr};
				REG_REM2_THR:  wb_dat_o <= {24'h0, rem2Thr};
				REG_SW_DUTY:   wb_dat_o <= {24'h0, swDutyReg};
				REG_LOOP_STAT: wb_dat_o <= {16'h0, fan2State, 2'h0,
				                            fan1State, 2'h0,
				                            fan2Duty, fan1Duty};
				default:       wb_dat_o <= 32'h0;
			endcase
		end
	end

	logic       autoMode;
	logic [1:0] chanSel;
	assign autoMode = fanControlConfig[AUTO_BIT];
	assign chanSel  = fanControlConfig[SEL_HI:SEL_LO];

	// Per-loop duty and on/hold flags, per fan minimum codes
	logic [3:0] minF1;
	logic [3:0] minF2;
	assign minF1 = minDutyConfig[3:0];
	assign minF2 = minDutyConfig[7:4];

	logic [3:0] r1F1;
	logic [3:0] r1F2;
	logic [3:0] r2F1;
	logic [3:0] r2F2;
	logic [3:0] lcF1;
	logic [3:0] lcF2;
	assign r1F1 = loop_duty(remote1Temp, rem1Thr, minF1);
	assign r1F2 = loop_duty(remote1Temp, rem1Thr, minF2);
	assign r2F1 = loop_duty(remote2Temp, rem2Thr, minF1);
	assign r2F2 = loop_duty(remote2Temp, rem2Thr, minF2);
	assign lcF1 = loop_duty(localTemp, localThr, minF1);
	assign lcF2 = loop_duty(localTemp, localThr, minF2);

	logic r1On;
	logic r2On;
	logic lcOn;
	logic r1Hold;
	logic r2Hold;
	logic lcHold;
	assign r1On   = above_on(remote1Temp, rem1Thr);
	assign r2On   = above_on(remote2Temp, rem2Thr);
	assign lcOn   = above_on(localTemp, localThr);
	assign r1Hold = hold_on(remote1Temp, rem1Thr);
	assign r2Hold = hold_on(remote2Temp, rem2Thr);
	assign lcHold = hold_on(localTemp, localThr);

	// Each combined loop counts only while its own channel is active
	logic [3:0] r1A1;
	logic [3:0] r2A1;
	logic [3:0] lcA1;
	logic [3:0] r1A2;
	logic [3:0] r2A2;
	logic [3:0] lcA2;
	assign r1A1 = r1Hold ? r1F1 : 4'h0;
	assign r2A1 = r2Hold ? r2F1 : 4'h0;
	assign lcA1 = lcHold ? lcF1 : 4'h0;
	assign r1A2 = r1Hold ? r1F2 : 4'h0;
	assign r2A2 = r2Hold ? r2F2 : 4'h0;
	assign lcA2 = lcHold ? lcF2 : 4'h0;

	// Channel selection per fan
	logic want1;
	logic want2;
	logic stay1;
	logic stay2;
	always_comb begin
		case (chanSel)
			2'b00: begin
				fan1Duty = r1F1;
				fan2Duty = r2F2;
				want1 = r1On;
				want2 = r2On;
				stay1 = r1Hold;
				stay2 = r2Hold;
			end
			2'b01: begin
				fan1Duty = r1F1;
				fan2Duty = r1F2;
				want1 = r1On;
				want2 = r1On;
				stay1 = r1Hold;
				stay2 = r1Hold;
			end
			2'b10: begin
				fan1Duty = r2F1;
				fan2Duty = r2F2;
				want1 = r2On;
				want2 = r2On;
				stay1 = r2Hold;
				stay2 = r2Hold;
			end
			default: begin
				fan1Duty = max4(max4(r1A1, r2A1), lcA1);
				fan2Duty = max4(max4(r1A2, r2A2), lcA2);
				want1 = r1On || r2On || lcOn;
				want2 = want1;
				stay1 = r1Hold || r2Hold || lcHold;
				stay2 = stay1;
			end
		endcase
	end

	// Fan 1 output stage
	afsl_fan_channel #(
		.SPIN_UNIT (SPIN_UNIT),
		.SLOT_CYC  (SLOT_CYC)
	) u_fan1 (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.autoMode (autoMode),
		.wantOn   (want1),
		.stayOn   (stay1),
		.loopDuty (fan1Duty),
		.swDuty   (swDutyReg[3:0]),
		.spinCode (fan1Characteristics[SPIN_HI:0]),
		.pwmOut   (fan1Pwm),
		.fanState (fan1State)
	);

	// Fan 2 output stage
	afsl_fan_channel #(
		.SPIN_UNIT (SPIN_UNIT),
		.SLOT_CYC  (SLOT_CYC)
	) u_fan2 (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.autoMode (autoMode),
		.wantOn   (want2),
		.stayOn   (stay2),
		.loopDuty (fan2Duty),
		.swDuty   (swDutyReg[7:4]),
		.spinCode (fan2Characteristics[SPIN_HI:0]),
		.pwmOut   (fan2Pwm),
		.fanState (fan2State)
	);
endmodule : auto_fan_speed_loop
`default_nettype wire

//--- test/afsl_fan_model.sv
// Fan model: PWM high time per period and length of the last high run
`timescale 1ns/10ps
`default_nettype none
module afsl_fan_model #(
	parameter int PERIOD = 30
) (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic pwm,
	output int        highCnt,
	output int        lastRun
);
	int phase;
	int acc;
	int run;
	// Duty per window and high-run length, as a fan motor would feel it
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase <= 0;
			acc <= 0;
			run <= 0;
			highCnt <= 0;
			lastRun <= 0;
		end else begin
			if (phase == PERIOD - 1) begin
				phase <= 0;
				highCnt <= acc + int'(pwm);
				acc <= 0;
			end else begin
				phase <= phase + 1;
				acc <= acc + int'(pwm);
			end
			if (pwm) begin
				run <= run + 1;
			end else if (run != 0) begin
				lastRun <= run;
				run <= 0;
			end
		end
	end
endmodule : afsl_fan_model
`default_nettype wire

//--- test/afsl_checker.sv
// Checker: bus handshake, register readback, hysteresis and manual PWM
`timescale 1ns/10ps
`default_nettype none
module afsl_checker
	import afsl_pkg::*;
#(
	parameter int SPIN_UNIT = SPIN_UNIT_CYC,
	parameter int SLOT_CYC  = PWM_SLOT_CYC
) (
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [7:0]  localTemp,
	input wire logic [7:0]  remote1Temp,
	input wire logic [7:0]  remote2Temp,
	input wire logic        fan1Pwm,
	input wire logic        fan2Pwm
);
	logic       take;
	logic [7:0] shCfg;
	logic [7:0] shMin;
	logic [7:0] shSw;
	logic [7:0] shRem1;
	logic [3:0] quiet;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Request accepted by the slave
	assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// Shadow copies of written registers
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			shCfg <= CONFIG_RST;
			shMin <= MIN_DUTY_RST;
			shSw <= SW_DUTY_RST;
			shRem1 <= REM_THR_RST;
		end else if (take && wb_we_i && wb_sel_i[0]) begin
			if (wb_adr_i == REG_CONFIG) shCfg <= wb_dat_i[7:0];
			if (wb_adr_i == REG_MIN_DUTY) shMin <= wb_dat_i[7:0];
			if (wb_adr_i == REG_SW_DUTY) shSw <= wb_dat_i[7:0];
			if (wb_adr_i == REG_REM1_THR) shRem1 <= wb_dat_i[7:0];
		end
	end
	// Cycles since the last write or remote 1 temperature change, saturating at 15
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) quiet <= 4'h0;
		else if ((take && wb_we_i) || $changed(remote1Temp)) quiet <= 4'h0;
		else if (quiet != 4'hF) quiet <= quiet + 4'h1;
	end
	property p_ack_next; take |=> wb_ack_o; endproperty
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	property p_ack_cause; wb_ack_o |-> $past(take); endproperty
	property p_unmapped;
		take && !wb_we_i && wb_adr_i == 8'h40 |=> wb_dat_o == 32'h0;
	endproperty
	property p_cfg_read;
		take && !wb_we_i && wb_adr_i == REG_CONFIG |=> wb_dat_o[7:0] == shCfg;
	endproperty
	property p_min_read;
		take && !wb_we_i && wb_adr_i == REG_MIN_DUTY |=> wb_dat_o[7:0] == shMin;
	endproperty
	property p_hyst_off;
		quiet == 4'hF && shCfg[7] && shCfg[6:5] == 2'b00 &&
		({1'b0, remote1Temp} + 9'd5 <= {2'b00, shRem1[7:3], 2'b00}) |-> !fan1Pwm;
	endproperty
	property p_man_off;
		quiet == 4'hF && !shCfg[7] && shSw[3:0] == 4'h0 |-> !fan1Pwm;
	endproperty
	property p_man_full;
		quiet == 4'hF && !shCfg[7] && shSw[7:4] == 4'hF |-> fan2Pwm;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack missing");
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
	a_unmapped: assert property (p_unmapped) else $error("unmapped nonzero");
	a_cfg_read: assert property (p_cfg_read) else $error("config bad");
	a_min_read: assert property (p_min_read) else $error("min bad");
	a_hyst_off: assert property (p_hyst_off) else $error("fan on");
	a_man_off: assert property (p_man_off) else $error("manual fan1 on");
	a_man_full: assert property (p_man_full) else $error("manual fan2 low");
	c_write: cover property (take && wb_we_i);
	c_fan1: cover property ($rose(fan1Pwm));
	c_off: cover property (p_hyst_off);
endmodule : afsl_checker
bind auto_fan_speed_loop afsl_checker #(.SPIN_UNIT(SPIN_UNIT),
	.SLOT_CYC(SLOT_CYC)) u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .localTemp(localTemp),
	.remote1Temp(remote1Temp), .remote2Temp(remote2Temp),
	.fan1Pwm(fan1Pwm), .fan2Pwm(fan2Pwm));
`default_nettype wire

//--- test/tb.sv
// Testbench: register bus tasks and fan control loop scenarios
`timescale 1ns/10ps
`default_nettype none
module tb;
	import afsl_pkg::*;
	localparam int SU = 20;
	localparam int SC = 2;
	localparam int PER = 15 * SC;
	logic ref_clk, rst_n, cyc, stb, we, ack, fan1Pwm, fan2Pwm;
	logic [7:0] adr, localTemp, remote1Temp, remote2Temp;
	logic [31:0] dat, datO, q;
	logic [3:0] sel;
	int hi1, hi2, run1, run2, num_errors, tests_run;
	int mult[8] = '{1, 2, 3, 4, 5, 10, 20, 40};
	logic [7:0] tt[8] = '{8'h21, 8'h28, 8'h29, 8'h2A, 8'h32, 8'h20, 8'h1C, 8'h1B};
	logic [3:0] dc[8] = '{4'h6, 4'hD, 4'hE, 4'hF, 4'hF, 4'h5, 4'h5, 4'h0};
	logic [3:0] e1[4] = '{4'h6, 4'h6, 4'h7, 4'h7};
	logic [3:0] e2[4] = '{4'hB, 4'hA, 4'hB, 4'hB};
	logic [7:0] sw[3] = '{8'hF0, 8'h0F, 8'h3A};
	auto_fan_speed_loop #(.SPIN_UNIT(SU), .SLOT_CYC(SC)) dut (.ref_clk(ref_clk),
		.rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(datO),
		.wb_ack_o(ack), .localTemp(localTemp), .remote1Temp(remote1Temp),
		.remote2Temp(remote2Temp), .fan1Pwm(fan1Pwm), .fan2Pwm(fan2Pwm));
	afsl_fan_model #(.PERIOD(PER)) fan1 (.ref_clk(ref_clk), .rst_n(rst_n),
		.pwm(fan1Pwm), .highCnt(hi1), .lastRun(run1));
	afsl_fan_model #(.PERIOD(PER)) fan2 (.ref_clk(ref_clk), .rst_n(rst_n),
		.pwm(fan2Pwm), .highCnt(hi2), .lastRun(run2));
	// Clock
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	task automatic chkVal(input logic [31:0] got, exp, input string what);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chkVal
	task automatic chkNear(input int got, exp, tol, input string what);
		tests_run++;
		if (got < exp - tol || got > exp + tol) begin
			num_errors++;
			$display("MISMATCH t=%0t %s got %0d exp %0d", $time, what, got, exp);
		end
	endtask : chkNear
	task automatic xfer(input logic w, input logic [7:0] a, d);
		int n;
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h000000, d};
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) chkVal(32'h0, 32'h1, "no ack");
		q = datO;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [7:0] a, d);
		xfer(1'b1, a, d);
	endtask : wr
	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 8'h00);
		chkVal(q, exp, "reg");
	endtask : rdChk
	task automatic chkFan(input bit f2, input afsl_state_t st,
		input logic [3:0] code);
		repeat (70) @(posedge ref_clk);
		xfer(1'b0, REG_LOOP_STAT, 8'h00);
		chkVal({30'h0, f2 ? q[15:14] : q[11:10]}, {30'h0, st}, "state");
		if (st == AFSL_RUN) chkVal({28'h0, f2 ? q[7:4] : q[3:0]}, {28'h0, code}, "duty");
		chkNear(f2 ? hi2 : hi1, st == AFSL_OFF ? 0 :
			(st == AFSL_SPIN ? PER : int'(code) * SC), 0, "pwm");
	endtask : chkFan
	task automatic summarize;
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize
	// Watchdog
	initial begin
		repeat (40000) @(posedge ref_clk);
		num_errors++;
		$display("MISMATCH t=%0t watchdog", $time);
		summarize();
	end
	// Main sequence
	initial begin
		{rst_n, cyc, stb, we, adr, dat, localTemp, remote1Temp, remote2Temp} = '0;
		sel = 4'hF;
		num_errors = 0;
		tests_run = 0;
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		rdChk(REG_CONFIG, 32'h80);
		rdChk(REG_FAN1_CHAR, 32'h1D);
		rdChk(REG_FAN2_CHAR, 32'h1D);
		rdChk(REG_MIN_DUTY, 32'h55);
		rdChk(8'h40, 32'h0);
		sel <= 4'h0;
		wr(REG_MIN_DUTY, 8'h00);
		sel <= 4'hF;
		rdChk(REG_MIN_DUTY, 32'h55);
		// Spin-up length per code, loop duty zero afterwards
		wr(REG_CONFIG, 8'h00);
		wr(REG_REM1_THR, 8'h44);
		wr(REG_MIN_DUTY, 8'h50);
		remote1Temp <= 8'd33;
		for (int c = 0; c < 8; c++) begin
			wr(REG_CONFIG, 8'h00);
			wr(REG_FAN1_CHAR, {5'b00011, c[2:0]});
			wr(REG_CONFIG, 8'h80);
			repeat (mult[c] * SU + 40) @(posedge ref_clk);
			chkNear(run1, mult[c] * SU, 2, "spin");
		end
		chkFan(1'b0, AFSL_RUN, 4'h0);
		// Slope, saturation and hysteresis
		remote1Temp <= 8'd0;
		wr(REG_REM1_THR, 8'h41);
		wr(REG_MIN_DUTY, 8'h55);
		chkFan(1'b0, AFSL_OFF, 4'h0);
		remote1Temp <= 8'd33;
		chkFan(1'b0, AFSL_SPIN, 4'hF);
		repeat (800) @(posedge ref_clk);
		for (int i = 0; i < 8; i++) begin
			remote1Temp <= tt[i];
			chkFan(1'b0, i == 7 ? AFSL_OFF : AFSL_RUN, dc[i]);
		end
		// Channel selection with per-fan minimum codes
		wr(REG_CONFIG, 8'h00);
		wr(REG_REM2_THR, 8'h20);
		wr(REG_FAN1_CHAR, 8'h18);
		wr(REG_FAN2_CHAR, 8'h18);
		wr(REG_MIN_DUTY, 8'h73);
		remote1Temp <= 8'd35;
		remote2Temp <= 8'd18;
		localTemp <= 8'd30;
		for (int s = 0; s < 4; s++) begin
			wr(REG_CONFIG, {1'b1, s[1:0], 5'h00});
			repeat (40) @(posedge ref_clk);
			chkFan(1'b0, AFSL_RUN, e1[s]);
			chkFan(1'b1, AFSL_RUN, e2[s]);
		end
		localTemp <= 8'd40;
		chkFan(1'b0, AFSL_RUN, 4'hF);
		chkFan(1'b1, AFSL_RUN, 4'hF);
		// Local loop with 40 and 20 degree ranges
		localTemp <= 8'h3C;
		wr(REG_LOCAL_THR, 8'h43);
		chkFan(1'b0, AFSL_RUN, 4'hA);
		chkFan(1'b1, AFSL_RUN, 4'hE);
		localTemp <= 8'h32;
		wr(REG_LOCAL_THR, 8'h42);
		chkFan(1'b0, AFSL_RUN, 4'hC);
		chkFan(1'b1, AFSL_RUN, 4'hF);
		// Software duty
		wr(REG_CONFIG, 8'h00);
		for (int v = 0; v < 3; v++) begin
			wr(REG_SW_DUTY, sw[v]);
			repeat (70) @(posedge ref_clk);
			chkNear(hi1, int'(sw[v][3:0]) * SC, 0, "sw1");
			chkNear(hi2, int'(sw[v][7:4]) * SC, 0, "sw2");
		end
		summarize();
	end
endmodule : tb
`default_nettype wire
